// ### fctc_card_model.sv
// Behavioural proximity card: answers one short frame per go pulse.
// Assumes the same clock as the controller; strobes last one cycle.
`timescale 1ns/1ns
module fctc_card_model (
  input wire logic clk_i,
  input wire logic go_i,
  output logic sof_o,
  output logic subc_o,
  output logic [7:0] byte_o,
  output logic valid_o,
  output logic end_o
);
  // ----------------------------------------------------------------
  // Frame: subcarrier, start of frame, one byte, end
  // ----------------------------------------------------------------
  initial begin
    sof_o = 1'b0;
    subc_o = 1'b0;
    byte_o = 8'h00;
    valid_o = 1'b0;
    end_o = 1'b0;
  end
  // Card never reads the reader FIFO, so early reads cannot occur
  always @(posedge clk_i) begin
    if (go_i) begin
      subc_o <= 1'b1;
      @(posedge clk_i);
      sof_o <= 1'b1;
      @(posedge clk_i);
      sof_o <= 1'b0;
      byte_o <= 8'hA5;
      valid_o <= 1'b1;
      @(posedge clk_i);
      valid_o <= 1'b0;
      byte_o <= 8'h5A;
      end_o <= 1'b1;
      @(posedge clk_i);
      end_o <= 1'b0;
      subc_o <= 1'b0;
    end
  end
endmodule

// ### fctc_frame_ctrl.sv
// Frame timing controller top: registers, transmit hold-off, rx framing.
// Assumes frontend strobes are one-cycle pulses on clk_i, Wishbone classic.
//
// Function
// RULE1 - Guard control resets to C0h
// RULE2 - Origin bit picks end of send or receive
// RULE3 - Unit is 16 carriers or half bit
// RULE4 - Guard count is eleven bits, upper three above
// RULE5 - Guard time is minimum gap before sending
// RULE6 - Stop field sets stop bit and extra guard
// RULE7 - Transmit parity appended to every byte
// RULE8 - Receive parity checked, not stored
// RULE9 - Stop symbol field selects sent stop symbol
// RULE10 - Start symbol field selects sent start symbol
// RULE11 - Frame start with enable raises interrupt
// RULE12 - Sticky frame start flag until cleared
// RULE13 - Subcarrier with enable raises interrupt
// RULE14 - Sticky subcarrier flag until cleared
// RULE15 - Live subcarrier status bit, read only
// RULE16 - Partial byte stored despite CRC when enabled
// RULE17 - Continuous receive does not end reception
// RULE18 - Continuous receive appends error register byte
// RULE19 - Early error discards bytes, resets FIFO
// RULE20 - Collision counts as error during suppression
// RULE21 - No completion interrupt in suppressed cases
// RULE22 - Software waits three bytes before reading
// RULE23 - Receive rate codes four to seven valid
// RULE24 - Transmission waits for guard timer expiry
// RULE25 - Flags cleared by writing zero, set wins
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
module fctc_frame_ctrl
  import fctc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_req_i,
  input wire logic tx_end_i,
  input wire logic half_bit_tick_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_byte_valid_i,
  input wire logic rx_sof_i,
  input wire logic rx_subc_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_parity_bit_i,
  input wire logic rx_byte_valid_i,
  input wire logic rx_partial_i,
  input wire logic rx_end_i,
  input wire logic rx_error_i,
  input wire logic rx_coll_i,
  input wire logic crc_en_i,
  input wire logic [7:0] error_reg_i,
  output logic tx_start_o,
  output logic tx_parity_o,
  output logic tx_parity_valid_o,
  output logic stop_bit_o,
  output logic [2:0] egt_units_o,
  output logic [1:0] start_symbol_sel_o,
  output logic [1:0] stop_symbol_sel_o,
  output logic rx_frame_start_irq_o,
  output logic rx_done_irq_o,
  output logic rx_stop_o,
  output logic continuous_receive_o,
  output logic [2:0] rx_rate_o,
  output logic rx_rate_valid_o,
  output logic rx_parity_err_o,
  output logic fifo_wr_o,
  output logic [7:0] fifo_wdata_o,
  output logic fifo_flush_o
);
  fctc_link_if lnk ();

  logic [7:0] ctrl, next_ctrl;
  logic [7:0] low, next_low;
  logic [7:0] frame, next_frame;
  logic [5:0] sofd, next_sofd;
  logic [7:0] rxc, next_rxc;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic acc, wr_lo;
  logic [7:0] idx;

  logic tx_busy, next_tx_busy;
  logic tx_start, next_tx_start;
  logic subc_prev, next_subc_prev;
  logic sof_irq, next_sof_irq;

  fctc_rx_state_type st, next_st;
  logic [1:0] nbytes, next_nbytes;
  logic err_pend, next_err_pend;
  logic err_d, next_err_d;
  logic fwr, next_fwr;
  logic [7:0] fdat, next_fdat;
  logic fflush, next_fflush;
  logic done_irq, next_done_irq;
  logic rx_stop, next_rx_stop;
  logic perr, next_perr;
  logic store, early_err;

  logic stop_bit, next_stop_bit;
  logic [2:0] egt, next_egt;
  logic tx_par, tx_pv;

  // ----------------------------------------------------------------
  // Sub-units
  // ----------------------------------------------------------------
  fctc_guard_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk.tmr)
  );

  fctc_parity #(
    .ODD_PARITY(1'b1)
  ) u_parity (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk.par)
  );

  assign lnk.start_evt = ctrl[BIT_WAIT_ORIGIN] ? rx_end_i : tx_end_i; // RULE2
  assign lnk.count = {ctrl[5:3], low}; // RULE4
  assign lnk.unit_sel = ctrl[BIT_WAIT_UNIT]; // RULE3
  assign lnk.half_tick = half_bit_tick_i;
  assign lnk.tx_byte = tx_byte_i;
  assign lnk.tx_valid = tx_byte_valid_i;
  assign lnk.tx_en = frame[BIT_TX_PARITY];
  assign lnk.rx_byte = rx_byte_i;
  assign lnk.rx_bit = rx_parity_bit_i;
  assign lnk.rx_valid = rx_byte_valid_i;
  assign lnk.rx_partial = rx_partial_i;
  assign lnk.rx_end = rx_end_i;
  assign lnk.rx_chk_en = frame[BIT_RX_PARITY];

  // ----------------------------------------------------------------
  // Wishbone slave and register file
  // ----------------------------------------------------------------
  always_comb begin
    acc = wb_cyc_i && wb_stb_i && !ack;
    idx = wb_adr_i[9:2];
    wr_lo = acc && wb_we_i && wb_sel_i[0];
    next_ack = acc;
    next_rdat = 32'h0000_0000;
    next_ctrl = ctrl;
    next_low = low;
    next_frame = frame;
    next_rxc = rxc;
    next_sofd = sofd;
    if (acc && !wb_we_i) begin
      case (idx)
        IDX_TX_GUARD_CONTROL: next_rdat = {24'h000000, ctrl};
        IDX_TX_GUARD_LOW: next_rdat = {24'h000000, low};
        IDX_FRAME_FORMAT_CFG: next_rdat = {24'h000000, frame};
        IDX_RX_START_DETECT: next_rdat = {26'h0000000, sofd};
        IDX_RX_BEHAVIOR_CFG: next_rdat = {24'h000000, rxc};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
    if (wr_lo) begin
      case (idx)
        IDX_TX_GUARD_CONTROL: next_ctrl = wb_dat_i[7:0];
        IDX_TX_GUARD_LOW: next_low = wb_dat_i[7:0];
        IDX_FRAME_FORMAT_CFG: next_frame = {wb_dat_i[7:6], 2'b00,
          wb_dat_i[3:0]};
        IDX_RX_START_DETECT: begin
          next_sofd[BIT_SOF_IRQ_EN] = wb_dat_i[BIT_SOF_IRQ_EN];
          next_sofd[BIT_SUBC_IRQ_EN] = wb_dat_i[BIT_SUBC_IRQ_EN];
          // Writing zero clears; writing one leaves the flag alone
          if (!wb_dat_i[BIT_SOF_SEEN]) begin
            next_sofd[BIT_SOF_SEEN] = 1'b0; // RULE25
          end
          if (!wb_dat_i[BIT_SUBC_SEEN]) begin
            next_sofd[BIT_SUBC_SEEN] = 1'b0; // RULE25
          end
        end
        IDX_RX_BEHAVIOR_CFG: next_rxc = {wb_dat_i[7:6], 2'b00,
          wb_dat_i[3:0]};
        default: next_ctrl = ctrl;
      endcase
    end
    // Hardware set comes last so it wins over a clear
    if (rx_sof_i) begin
      next_sofd[BIT_SOF_SEEN] = 1'b1; // RULE12
    end
    if (rx_subc_i) begin
      next_sofd[BIT_SUBC_SEEN] = 1'b1; // RULE14
    end
    next_sofd[BIT_SUBC_LIVE] = rx_subc_i; // RULE15
    next_sofd[3] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= RST_TX_GUARD_CONTROL; // RULE1
      low <= RST_TX_GUARD_LOW;
      frame <= RST_FRAME_FORMAT_CFG;
      sofd <= RST_RX_START_DETECT[5:0];
      rxc <= RST_RX_BEHAVIOR_CFG;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      low <= next_low;
      frame <= next_frame;
      sofd <= next_sofd;
      rxc <= next_rxc;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // ----------------------------------------------------------------
  // Transmit hold-off and framing selects
  // ----------------------------------------------------------------
  always_comb begin
    next_tx_start = tx_req_i && lnk.expired && !tx_busy && !tx_start; // RULE24
    next_tx_busy = tx_busy;
    if (tx_start) begin
      next_tx_busy = 1'b1;
    end
    if (tx_end_i) begin
      next_tx_busy = 1'b0;
    end
    next_stop_bit = (ctrl[2:0] != 3'h0); // RULE6
    next_egt = (ctrl[2:0] > 3'h1) ? ctrl[2:0] - 3'h1 : 3'h0; // RULE6
    next_subc_prev = rx_subc_i;
    next_sof_irq = (rx_sof_i && sofd[BIT_SOF_IRQ_EN]) || // RULE11
      (rx_subc_i && !subc_prev && sofd[BIT_SUBC_IRQ_EN]); // RULE13
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_start <= 1'b0;
      tx_busy <= 1'b0;
      stop_bit <= 1'b0;
      egt <= 3'h0;
      subc_prev <= 1'b0;
      sof_irq <= 1'b0;
    end else begin
      tx_start <= next_tx_start;
      tx_busy <= next_tx_busy;
      stop_bit <= next_stop_bit;
      egt <= next_egt;
      subc_prev <= next_subc_prev;
      sof_irq <= next_sof_irq;
    end
  end

  // ----------------------------------------------------------------
  // Receive path: FIFO writes, suppression, completion
  // ----------------------------------------------------------------
  always_comb begin
    next_err_d = rx_error_i || rx_coll_i; // RULE20
    store = lnk.rx_q_valid && (!lnk.rx_q_partial || // RULE16
      rxc[BIT_PARTIAL] || !crc_en_i);
    early_err = rxc[BIT_EMD] && (st == RX_EARLY) &&
      (lnk.rx_q_perr || err_d); // RULE19
    next_perr = lnk.rx_q_perr;
    next_st = st;
    next_nbytes = nbytes;
    next_fwr = 1'b0;
    next_fdat = fdat;
    next_fflush = 1'b0;
    next_done_irq = 1'b0;
    next_rx_stop = 1'b0;
    next_err_pend = err_pend;
    if (rx_sof_i) begin
      next_st = RX_EARLY;
      next_nbytes = 2'h0;
    end else if (early_err) begin
      // Early bytes treated as disturbance; frame is dropped
      next_fflush = 1'b1; // RULE19
      next_st = RX_IDLE;
    end else if (store) begin
      next_fwr = 1'b1;
      next_fdat = lnk.rx_q_byte;
      if (st == RX_EARLY) begin
        next_nbytes = nbytes + 2'h1;
        if (nbytes == EMD_BYTES_LAST) begin
          next_st = RX_BODY;
        end
      end
    end else if (err_pend) begin
      next_fwr = 1'b1;
      next_fdat = error_reg_i; // RULE18
      next_err_pend = 1'b0;
    end
    if (lnk.rx_q_end && !early_err) begin
      if (rxc[BIT_EMD] && (st == RX_EARLY)) begin
        next_fflush = 1'b1; // RULE21
      end else if (!(rxc[BIT_EMD] && (st == RX_IDLE))) begin
        // A frame already dropped as disturbance stays silent
        next_done_irq = 1'b1; // RULE21
      end
      next_err_pend = rxc[BIT_CONTINUOUS]; // RULE18
      next_rx_stop = !rxc[BIT_CONTINUOUS]; // RULE17
      next_st = RX_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RX_IDLE;
      nbytes <= 2'h0;
      err_pend <= 1'b0;
      err_d <= 1'b0;
      fwr <= 1'b0;
      fdat <= 8'h00;
      fflush <= 1'b0;
      done_irq <= 1'b0;
      rx_stop <= 1'b0;
      perr <= 1'b0;
    end else begin
      st <= next_st;
      nbytes <= next_nbytes;
      err_pend <= next_err_pend;
      err_d <= next_err_d;
      fwr <= next_fwr;
      fdat <= next_fdat;
      fflush <= next_fflush;
      done_irq <= next_done_irq;
      rx_stop <= next_rx_stop;
      perr <= next_perr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;
  assign tx_start_o = tx_start;
  assign tx_parity_o = lnk.tx_par;
  assign tx_parity_valid_o = lnk.tx_par_valid;
  assign stop_bit_o = stop_bit;
  assign egt_units_o = egt;
  assign start_symbol_sel_o = frame[1:0]; // RULE10
  assign stop_symbol_sel_o = frame[3:2]; // RULE9
  assign rx_frame_start_irq_o = sof_irq;
  assign rx_done_irq_o = done_irq;
  assign rx_stop_o = rx_stop;
  assign continuous_receive_o = rxc[BIT_CONTINUOUS]; // RULE17
  assign rx_rate_o = rxc[2:0];
  assign rx_rate_valid_o = rxc[2]; // RULE23
  assign rx_parity_err_o = perr;
  assign fifo_wr_o = fwr;
  assign fifo_wdata_o = fdat;
  assign fifo_flush_o = fflush;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_ctrl;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (ctrl == 8'hC0);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) // RULE1
    else $error("guard control reset value wrong");

  property p_hold_off;
    @(posedge clk_i) disable iff (rst_i)
    tx_start_o |-> $past(lnk.expired) && !$past(tx_busy);
  endproperty
  a_hold_off: assert property (p_hold_off) // RULE24
    else $error("transmission started inside guard time");

  property p_origin;
    @(posedge clk_i) disable iff (rst_i)
    tx_end_i && !ctrl[BIT_WAIT_ORIGIN] && (lnk.count != 11'h000)
      |=> !lnk.expired ##1 !tx_start_o;
  endproperty
  a_origin: assert property (p_origin) // RULE2
    else $error("guard time not started at end of send");

  property p_sof_seen;
    @(posedge clk_i) disable iff (rst_i)
    rx_sof_i |=> sofd[BIT_SOF_SEEN] [*2] or (sofd[BIT_SOF_SEEN] ##1 wr_lo);
  endproperty
  a_sof_seen: assert property (p_sof_seen) // RULE12
    else $error("frame start flag not set or lost");

  property p_subc_seen;
    @(posedge clk_i) disable iff (rst_i)
    rx_subc_i |=> sofd[BIT_SUBC_SEEN] && sofd[BIT_SUBC_LIVE];
  endproperty
  a_subc_seen: assert property (p_subc_seen) // RULE14
    else $error("subcarrier flags not set");

  property p_sof_irq;
    @(posedge clk_i) disable iff (rst_i)
    rx_sof_i && sofd[BIT_SOF_IRQ_EN] |=> rx_frame_start_irq_o;
  endproperty
  a_sof_irq: assert property (p_sof_irq) // RULE11
    else $error("frame start interrupt missing");

  property p_emd_flush;
    @(posedge clk_i) disable iff (rst_i)
    early_err && !rx_sof_i |=> fifo_flush_o && !rx_done_irq_o && !fifo_wr_o;
  endproperty
  a_emd_flush: assert property (p_emd_flush) // RULE19
    else $error("early error did not reset the FIFO");

  property p_drop_quiet;
    @(posedge clk_i) disable iff (rst_i)
    early_err |=> (!rx_done_irq_o) [*2];
  endproperty
  a_drop_quiet: assert property (p_drop_quiet) // RULE21
    else $error("completion raised for a dropped frame");

  property p_stop_len;
    @(posedge clk_i) disable iff (rst_i)
    $stable(ctrl) |=> stop_bit_o == ($past(ctrl[2:0]) != 3'h0);
  endproperty
  a_stop_len: assert property (p_stop_len) // RULE6
    else $error("stop bit select wrong");

  property p_rate;
    @(posedge clk_i) disable iff (rst_i)
    rx_rate_valid_o |-> (rx_rate_o >= 3'h4);
  endproperty
  a_rate: assert property (p_rate) // RULE23
    else $error("reserved rate flagged valid");
endmodule

// ### fctc_guard_timer.sv
// Guard timer: loads the guard count at its start event, counts units.
// Assumes start events and ticks are one-cycle pulses on clk_i.
`timescale 1ns/1ns
module fctc_guard_timer
  import fctc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  fctc_link_if.tmr lnk
);
  logic [3:0] div, next_div;
  logic [10:0] cnt, next_cnt;
  logic run, next_run;
  logic exp_q, next_exp;
  logic unit_tick;

  // ----------------------------------------------------------------
  // Unit divider and countdown
  // ----------------------------------------------------------------
  always_comb begin
    next_div = (div == DIV_LAST) ? 4'h0 : div + 4'h1;
    unit_tick = lnk.unit_sel ? lnk.half_tick : (div == DIV_LAST); // RULE3
    next_cnt = cnt;
    next_run = run;
    if (lnk.start_evt) begin
      // Restart the divider so the first unit is a whole one
      next_div = 4'h0;
      next_cnt = lnk.count;
      next_run = (lnk.count != 11'h000);
    end else if (run && unit_tick) begin
      next_cnt = cnt - 11'h001;
      if (cnt == 11'h001) begin
        next_run = 1'b0;
      end
    end
    next_exp = !next_run;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 4'h0;
      cnt <= 11'h000;
      run <= 1'b0;
      exp_q <= 1'b1;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
      run <= next_run;
      exp_q <= next_exp;
    end
  end

  assign lnk.expired = exp_q;

  property p_load_blocks;
    @(posedge clk_i) disable iff (rst_i)
    lnk.start_evt && (lnk.count != 11'h000) |=> !lnk.expired;
  endproperty
  a_load_blocks: assert property (p_load_blocks) // RULE5
    else $error("guard timer did not start");
endmodule

// ### fctc_link_if.sv
// Internal carrier between the controller and its timer and parity units.
// Assumes all parties run on the same clock.
`timescale 1ns/1ns
interface fctc_link_if;
  logic start_evt;
  logic [10:0] count;
  logic unit_sel;
  logic half_tick;
  logic expired;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_en;
  logic tx_par;
  logic tx_par_valid;
  logic [7:0] rx_byte;
  logic rx_bit;
  logic rx_valid;
  logic rx_partial;
  logic rx_end;
  logic rx_chk_en;
  logic [7:0] rx_q_byte;
  logic rx_q_valid;
  logic rx_q_partial;
  logic rx_q_end;
  logic rx_q_perr;

  modport ctl(output start_evt, count, unit_sel, half_tick, tx_byte,
    tx_valid, tx_en, rx_byte, rx_bit, rx_valid, rx_partial, rx_end,
    rx_chk_en, input expired, tx_par, tx_par_valid, rx_q_byte,
    rx_q_valid, rx_q_partial, rx_q_end, rx_q_perr);
  modport tmr(input start_evt, count, unit_sel, half_tick,
    output expired);
  modport par(input tx_byte, tx_valid, tx_en, rx_byte, rx_bit, rx_valid,
    rx_partial, rx_end, rx_chk_en, output tx_par, tx_par_valid, rx_q_byte,
    rx_q_valid, rx_q_partial, rx_q_end, rx_q_perr);
endinterface

// ### fctc_parity.sv
// Parity unit: makes transmit parity and checks receive parity.
// Assumes byte strobes are one-cycle pulses; outputs lag by one cycle.
`timescale 1ns/1ns
module fctc_parity
  import fctc_pkg::*;
#(
  parameter bit ODD_PARITY = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  fctc_link_if.par lnk
);
  logic tx_par, next_tx_par, tx_pv, next_tx_pv;
  logic [7:0] rq_byte, next_rq_byte;
  logic rq_valid, next_rq_valid, rq_part, next_rq_part;
  logic rq_end, next_rq_end, rq_perr, next_rq_perr;

  // ----------------------------------------------------------------
  // Parity logic
  // ----------------------------------------------------------------
  always_comb begin
    next_tx_par = (^lnk.tx_byte) ^ ODD_PARITY; // RULE7
    next_tx_pv = lnk.tx_valid && lnk.tx_en; // RULE7
    // Parity bit is checked only, never passed on with the byte
    next_rq_byte = lnk.rx_byte; // RULE8
    next_rq_valid = lnk.rx_valid;
    next_rq_part = lnk.rx_partial;
    next_rq_end = lnk.rx_end;
    next_rq_perr = lnk.rx_valid && lnk.rx_chk_en && !lnk.rx_partial &&
      ((^lnk.rx_byte) ^ ODD_PARITY ^ lnk.rx_bit); // RULE8
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_par <= 1'b0;
      tx_pv <= 1'b0;
      rq_byte <= 8'h00;
      rq_valid <= 1'b0;
      rq_part <= 1'b0;
      rq_end <= 1'b0;
      rq_perr <= 1'b0;
    end else begin
      tx_par <= next_tx_par;
      tx_pv <= next_tx_pv;
      rq_byte <= next_rq_byte;
      rq_valid <= next_rq_valid;
      rq_part <= next_rq_part;
      rq_end <= next_rq_end;
      rq_perr <= next_rq_perr;
    end
  end

  assign lnk.tx_par = tx_par;
  assign lnk.tx_par_valid = tx_pv;
  assign lnk.rx_q_byte = rq_byte;
  assign lnk.rx_q_valid = rq_valid;
  assign lnk.rx_q_partial = rq_part;
  assign lnk.rx_q_end = rq_end;
  assign lnk.rx_q_perr = rq_perr;

  property p_tx_parity;
    @(posedge clk_i) disable iff (rst_i)
    lnk.tx_valid && lnk.tx_en |=>
      lnk.tx_par_valid && (lnk.tx_par == ((^$past(lnk.tx_byte)) ^ ODD_PARITY));
  endproperty
  a_tx_parity: assert property (p_tx_parity) // RULE7
    else $error("transmit parity wrong or missing");
endmodule

// ### fctc_pkg.sv
// Shared constants for the frame timing controller.
// Assumes a single 10 MHz clock and word-aligned register access.
package fctc_pkg;

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TX_GUARD_CONTROL = 8'h31;
  localparam logic [7:0] IDX_TX_GUARD_LOW = 8'h32;
  localparam logic [7:0] IDX_FRAME_FORMAT_CFG = 8'h33;
  localparam logic [7:0] IDX_RX_START_DETECT = 8'h34;
  localparam logic [7:0] IDX_RX_BEHAVIOR_CFG = 8'h35;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TX_GUARD_CONTROL = 8'hC0;
  localparam logic [7:0] RST_TX_GUARD_LOW = 8'h00;
  localparam logic [7:0] RST_FRAME_FORMAT_CFG = 8'h00;
  localparam logic [7:0] RST_RX_START_DETECT = 8'h00;
  localparam logic [7:0] RST_RX_BEHAVIOR_CFG = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WAIT_ORIGIN = 7;
  localparam int BIT_WAIT_UNIT = 6;
  localparam int BIT_TX_PARITY = 7;
  localparam int BIT_RX_PARITY = 6;
  localparam int BIT_SOF_IRQ_EN = 5;
  localparam int BIT_SOF_SEEN = 4;
  localparam int BIT_SUBC_IRQ_EN = 2;
  localparam int BIT_SUBC_SEEN = 1;
  localparam int BIT_SUBC_LIVE = 0;
  localparam int BIT_PARTIAL = 7;
  localparam int BIT_CONTINUOUS = 6;
  localparam int BIT_EMD = 3;
  localparam logic [1:0] EMD_BYTES_LAST = 2'h2;

  // ----------------------------------------------------------------
  // Timing: one guard unit is 16 carrier periods
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int CARRIER_KHZ = 13560;
  localparam int UNIT_CARRIERS = 16;
  localparam int CARRIER16_CYC =
    (UNIT_CARRIERS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
  localparam logic [3:0] DIV_LAST = 4'(CARRIER16_CYC - 1);

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_EARLY = 2'b01,
    RX_BODY = 2'b11
  } fctc_rx_state_type;

endpackage

// ### test_fctc_frame_ctrl.sv
// Self-checking bench for the frame timing controller.
// Assumes Wishbone classic access and the card model on the rx side.
`timescale 1ns/1ns
module test_fctc_frame_ctrl import fctc_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, tx_req = 1'b0, tx_end = 1'b0, tbv = 1'b0, go = 1'b0;
  logic sof, subc, rbv, rend, txs, par, parv, stopb, irq, fwr, flush, done;
  logic stopr, perr, rpb = 1'b1, rerr = 1'b0;
  logic [7:0] tbyte = 8'h03;
  logic [3:0] ev;
  logic [7:0] rb, fdat, q;
  logic [2:0] egt;
  logic [1:0] ssym, esym;
  int error_cnt = 0, compares = 0, n, k, m;
  always #50 clk_i = ~clk_i;
  fctc_card_model card_u (.clk_i(clk_i), .go_i(go), .sof_o(sof),
    .subc_o(subc), .byte_o(rb), .valid_o(rbv), .end_o(rend));
  fctc_frame_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_req_i(tx_req),
    .tx_end_i(tx_end), .half_bit_tick_i(1'b0), .tx_byte_i(tbyte),
    .tx_byte_valid_i(tbv), .rx_sof_i(sof), .rx_subc_i(subc),
    .rx_byte_i(rb), .rx_parity_bit_i(rpb), .rx_byte_valid_i(rbv),
    .rx_partial_i(1'b0), .rx_end_i(rend), .rx_error_i(rerr & rbv),
    .rx_coll_i(1'b0), .crc_en_i(1'b0), .error_reg_i(rb),
    .tx_start_o(txs), .tx_parity_o(par), .tx_parity_valid_o(parv),
    .stop_bit_o(stopb), .egt_units_o(egt), .start_symbol_sel_o(ssym),
    .stop_symbol_sel_o(esym), .rx_frame_start_irq_o(irq),
    .rx_done_irq_o(done), .rx_stop_o(stopr), .continuous_receive_o(),
    .rx_rate_o(), .rx_rate_valid_o(), .rx_parity_err_o(perr),
    .fifo_wr_o(fwr), .fifo_wdata_o(fdat), .fifo_flush_o(flush));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("Errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_TX_GUARD_CONTROL, 8'h00);
    chk(q, 8'hC0);
    wb(1'b0, IDX_RX_BEHAVIOR_CFG, 8'h00);
    chk(q, RST_RX_BEHAVIOR_CFG);
    wb(1'b0, 8'h3F, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, IDX_FRAME_FORMAT_CFG, 8'hFE);
    wb(1'b0, IDX_FRAME_FORMAT_CFG, 8'h00);
    chk(q, 8'hCE);
    chk({esym, ssym}, 4'hE);
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      tbv <= 1'b1;
      tbyte <= k ? 8'h07 : 8'h03;
      @(posedge clk_i);
      tbv <= 1'b0;
      for (n = 0; n < 4 && parv !== 1'b1; n++) @(posedge clk_i);
      chk({parv, par}, {1'b1, k == 0});
    end
    wb(1'b1, IDX_TX_GUARD_CONTROL, 8'h0F);
    // Selects settle one edge after the write lands
    @(posedge clk_i);
    chk({stopb, egt}, 4'hE);
    wb(1'b1, IDX_TX_GUARD_LOW, 8'h01);
    tx_req <= 1'b1;
    for (n = 0; n < 20 && txs !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    tx_end <= 1'b1;
    @(posedge clk_i);
    tx_end <= 1'b0;
    // Count 257 in units of 12 clocks before the next start
    for (n = 0; n < 4000 && txs !== 1'b1; n++) @(posedge clk_i);
    chk(n >= 3084 && n <= 3088, 1'b1);
    tx_req <= 1'b0;
    wb(1'b1, IDX_RX_START_DETECT, 8'h20);
    // Clean frame, then parity and receive errors with suppression on
    for (m = 0; m < 3; m++) begin
      if (m == 1) wb(1'b1, IDX_RX_BEHAVIOR_CFG, 8'h0C);
      rpb <= (m != 1);
      rerr <= (m == 2);
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      k = 0;
      q = 8'h00;
      ev = 4'h0;
      repeat (12) begin
        @(posedge clk_i);
        if (irq === 1'b1) k++;
        if (fwr === 1'b1) q = fdat;
        ev = ev | {flush, done, stopr, perr};
      end
      chk(k, 1);
      chk(q, (m == 0) ? 8'hA5 : 8'h00);
      chk(ev, (m == 0) ? 4'h6 : (m == 1) ? 4'hB : 4'hA);
    end
    wb(1'b0, IDX_RX_START_DETECT, 8'h00);
    chk(q, 8'h32);
    wb(1'b1, IDX_RX_START_DETECT, 8'h20);
    wb(1'b0, IDX_RX_START_DETECT, 8'h00);
    chk(q, 8'h20);
    report_and_stop;
  end
endmodule
